// ### inc/ttl_pkg.sv
// Purpose: Shared constants and types for the temperature threshold limit bank.
// Assumes: 8-bit register port, 16-bit conversion results, one clock.
// Notes: Each threshold is a byte pair; masks give the writable bits.
`default_nettype none
package ttl_pkg;
  localparam int NUM_PAIRS = 3;
  localparam int PAIR_LOW = 0;
  localparam int PAIR_CRIT_HIGH = 1;
  localparam int PAIR_CRIT_LOW = 2;

  localparam logic [7:0] ADDR_LOW_LIMIT_LO = 8'h1e;
  localparam logic [7:0] ADDR_LOW_LIMIT_HI = 8'h1f;
  localparam logic [7:0] ADDR_CRIT_HIGH_LIMIT_LO = 8'h20;
  localparam logic [7:0] ADDR_CRIT_HIGH_LIMIT_HI = 8'h21;
  localparam logic [7:0] ADDR_CRIT_LOW_LIMIT_LO = 8'h22;
  localparam logic [7:0] ADDR_CRIT_LOW_LIMIT_HI = 8'h23;
  localparam logic [7:0] ADDR_SENSED_TEMP_LO = 8'h31;
  localparam logic [7:0] ADDR_SENSED_TEMP_HI = 8'h32;
  localparam logic [7:0] ADDR_TEMP_FLAG = 8'h33;
  localparam logic [7:0] ADDR_PAIR_STEP = 8'h01;

  // Writable bits: low byte 7:2, high byte 4:0
  localparam logic [7:0] LO_BYTE_MASK = 8'hfc;
  localparam logic [7:0] HI_BYTE_MASK = 8'h1f;

  localparam logic [7:0] LOW_LIMIT_LO_RST = 8'h00;
  localparam logic [7:0] LOW_LIMIT_HI_RST = 8'h00;
  localparam logic [7:0] CRIT_HIGH_LIMIT_LO_RST = 8'h50;
  localparam logic [7:0] CRIT_HIGH_LIMIT_HI_RST = 8'h05;
  localparam logic [7:0] CRIT_LOW_LIMIT_LO_RST = 8'h00;
  localparam logic [7:0] CRIT_LOW_LIMIT_HI_RST = 8'h00;
  localparam logic [15:0] SENSED_TEMP_RST = 16'h0000;
  localparam logic [3:0] TEMP_FLAG_RST = 4'h0;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

  localparam logic [7:0] PAIR_ADDR_LO [NUM_PAIRS] =
    '{ADDR_LOW_LIMIT_LO, ADDR_CRIT_HIGH_LIMIT_LO, ADDR_CRIT_LOW_LIMIT_LO};
  localparam logic [7:0] PAIR_RST_LO [NUM_PAIRS] =
    '{LOW_LIMIT_LO_RST, CRIT_HIGH_LIMIT_LO_RST, CRIT_LOW_LIMIT_LO_RST};
  localparam logic [7:0] PAIR_RST_HI [NUM_PAIRS] =
    '{LOW_LIMIT_HI_RST, CRIT_HIGH_LIMIT_HI_RST, CRIT_LOW_LIMIT_HI_RST};

  // Bit positions in the temperature flag register
  localparam int FLAG_OVER_HIGH = 0;
  localparam int FLAG_UNDER_LOW = 1;
  localparam int FLAG_OVER_CRIT_HIGH = 2;
  localparam int FLAG_UNDER_CRIT_LOW = 3;

  typedef enum logic [1:0] {
    CMP_IDLE = 2'b00,
    CMP_LOAD = 2'b01,
    CMP_EVAL = 2'b11
  } ttl_cmp_state_t;
endpackage
`default_nettype wire

// ### inc/ttl_cmp_if.sv
// Purpose: Carries a frozen comparison snapshot and its four results.
// Assumes: Snapshot side registers all fields; unit side is combinational.
// Notes: Limits are full 16-bit pair values.
`default_nettype none
interface ttl_cmp_if;
  logic [15:0] temp;
  logic [15:0] highLim;
  logic [15:0] lowLim;
  logic [15:0] critHighLim;
  logic [15:0] critLowLim;
  logic [3:0] hit;
  modport snap (output temp, highLim, lowLim, critHighLim, critLowLim, input hit);
  modport unit (input temp, highLim, lowLim, critHighLim, critLowLim, output hit);
endinterface
`default_nettype wire

// ### core/ttl_limit_pair.sv
// Purpose: One threshold held as a low byte and a high byte.
// Assumes: Writes come from the register port on the same clock.
// Notes: Read-only bits are never stored, so they read zero.
`default_nettype none
module ttl_limit_pair #(
  parameter logic [7:0] ADDR_LO = 8'h00,
  parameter logic [7:0] RST_LO = 8'h00,
  parameter logic [7:0] RST_HI = 8'h00
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  output logic [15:0] value
);
  import ttl_pkg::*;

  logic [7:0] loByte;
  logic [7:0] hiByte;
  logic [7:0] addrHi;

  assign addrHi = 8'(ADDR_LO + ADDR_PAIR_STEP);
  assign value = {hiByte, loByte};

  always_ff @(posedge mclk) begin
    if (rst) begin
      loByte <= RST_LO & LO_BYTE_MASK; // R8
    end else if (ce && wrEn && wrAddr == ADDR_LO) begin
      loByte <= wrData & LO_BYTE_MASK; // R7 R11
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hiByte <= RST_HI & HI_BYTE_MASK; // R8
    end else if (ce && wrEn && wrAddr == addrHi) begin
      hiByte <= wrData & HI_BYTE_MASK; // R7
    end
  end
endmodule
`default_nettype wire

// ### core/ttl_compare.sv
// Purpose: Compares a snapshot temperature against four thresholds.
// Assumes: Snapshot is stable for the whole evaluation cycle.
// Notes: Unsigned 16-bit compare of the full pair values.
`default_nettype none
module ttl_compare (
  ttl_cmp_if.unit cmp
);
  import ttl_pkg::*;

  always_comb begin
    cmp.hit = TEMP_FLAG_RST;
    cmp.hit[FLAG_OVER_HIGH] = cmp.temp > cmp.highLim; // R12 R15
    cmp.hit[FLAG_UNDER_LOW] = cmp.temp < cmp.lowLim; // R1 R15
    cmp.hit[FLAG_OVER_CRIT_HIGH] = cmp.temp > cmp.critHighLim; // R2 R15
    cmp.hit[FLAG_UNDER_CRIT_LOW] = cmp.temp < cmp.critLowLim; // R3 R15
  end
endmodule
`default_nettype wire

// ### core/ttl_limit_bank.sv
// Purpose: Threshold register bank with conversion compare and status flags.
// Assumes: Register port and conversion strobe come from logic on mclk.
// Notes: The newest pending conversion is snapshotted with the limits of that moment.
//
// How it works
// (R1) Low flag set when latest result is below the low-limit pair.
// (R2) Critical-high flag set when latest result exceeds critical-high pair.
// (R3) Critical-low flag set when latest result is below critical-low pair.
// (R4) Low-limit pair lives at 1Eh (low byte) and 1Fh (high byte).
// (R5) Critical-high pair lives at 20h (low byte) and 21h (high byte).
// (R6) Critical-low pair lives at 22h (low byte) and 23h (high byte).
// (R7) Low-byte bits 1:0 and high-byte bits 7:5 ignore writes, read zero.
// (R8) Reset: critical-high pair 50h/05h, other pairs all 00h.
// (R9) Host keeps critical-high above high; the bank does not check.
// (R10) Host keeps critical-low below low; the bank does not check.
// (R11) Writable threshold bits read back and hold until write or reset.
// (R12) High flag set when latest result exceeds the external high pair.
// (R13) Four flags read-only at 33h, bits 0 to 3: high, low, crit-high, crit-low.
// (R14) Compared value is latest result, readable at 31h and 32h.
// (R15) Every new result re-evaluates all flags on full 16-bit values; a result replaced while pending is skipped.
// (R16) Threshold writes apply from the next comparison, not one in progress.
`default_nettype none
module ttl_limit_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  output logic regAccErr,
  input wire logic convValid,
  input wire logic [15:0] convData,
  input wire logic [15:0] highLimit,
  output logic overHighFlag,
  output logic underLowFlag,
  output logic overCritHighFlag,
  output logic underCritLowFlag,
  output logic cmpBusy
);
  import ttl_pkg::*;

  ttl_cmp_if cmp ();

  logic [15:0] pairValue [NUM_PAIRS];
  logic [15:0] sensedTemp;
  logic [15:0] pendData;
  logic pendValid;
  logic [3:0] tempFlag;
  ttl_cmp_state_t state;
  ttl_cmp_state_t next_state;
  logic [7:0] next_rdData;
  logic addrMapped;
  logic addrWritable;

  genvar i;
  generate
    for (i = 0; i < NUM_PAIRS; i++) begin : g_pair
      ttl_limit_pair #(
        .ADDR_LO(PAIR_ADDR_LO[i]),
        .RST_LO(PAIR_RST_LO[i]),
        .RST_HI(PAIR_RST_HI[i])
      ) u_pair (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .wrEn(regWrEn),
        .wrAddr(regAddr),
        .wrData(regWrData),
        .value(pairValue[i])
      ); // R4 R5 R6
    end
  endgenerate

  ttl_compare u_compare (
    .cmp(cmp)
  );

  // Latest result waits here until the compare path is free; newest wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      pendData <= SENSED_TEMP_RST;
    end else if (ce && convValid) begin
      pendData <= convData;
    end
  end

  // A new strobe in the taking cycle keeps the request alive
  always_ff @(posedge mclk) begin
    if (rst) begin
      pendValid <= 1'b0;
    end else if (ce) begin
      if (convValid) begin
        pendValid <= 1'b1; // R15
      end else if (state == CMP_LOAD) begin
        pendValid <= 1'b0;
      end
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      CMP_IDLE: begin
        if (pendValid) begin
          next_state = CMP_LOAD;
        end
      end
      CMP_LOAD: begin
        next_state = CMP_EVAL;
      end
      CMP_EVAL: begin
        next_state = CMP_IDLE;
      end
      default: begin
        next_state = CMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= CMP_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Limits are frozen with the result; later writes wait for the next one
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmp.temp <= SENSED_TEMP_RST;
      cmp.highLim <= SENSED_TEMP_RST;
      cmp.lowLim <= SENSED_TEMP_RST;
      cmp.critHighLim <= SENSED_TEMP_RST;
      cmp.critLowLim <= SENSED_TEMP_RST;
    end else if (ce && state == CMP_LOAD) begin
      cmp.temp <= pendData; // R14
      cmp.highLim <= highLimit; // R16
      cmp.lowLim <= pairValue[PAIR_LOW]; // R16
      cmp.critHighLim <= pairValue[PAIR_CRIT_HIGH]; // R16
      cmp.critLowLim <= pairValue[PAIR_CRIT_LOW]; // R16
    end
  end

  // Result becomes visible to the host with the snapshot
  always_ff @(posedge mclk) begin
    if (rst) begin
      sensedTemp <= SENSED_TEMP_RST;
    end else if (ce && state == CMP_LOAD) begin
      sensedTemp <= pendData; // R14
    end
  end

  // Flags follow each evaluation; they are levels, not sticky events
  always_ff @(posedge mclk) begin
    if (rst) begin
      tempFlag <= TEMP_FLAG_RST;
    end else if (ce && state == CMP_EVAL) begin
      tempFlag <= cmp.hit; // R1 R2 R3 R12 R15
    end
  end

  assign overHighFlag = tempFlag[FLAG_OVER_HIGH];
  assign underLowFlag = tempFlag[FLAG_UNDER_LOW];
  assign overCritHighFlag = tempFlag[FLAG_OVER_CRIT_HIGH];
  assign underCritLowFlag = tempFlag[FLAG_UNDER_CRIT_LOW];

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmpBusy <= 1'b0;
    end else if (ce) begin
      cmpBusy <= next_state != CMP_IDLE;
    end
  end

  // Read mux; unmapped addresses return zero
  always_comb begin
    next_rdData = READ_IDLE_VALUE;
    addrWritable = 1'b0;
    for (int k = 0; k < NUM_PAIRS; k++) begin
      if (regAddr == PAIR_ADDR_LO[k]) begin
        next_rdData = pairValue[k][7:0]; // R11
        addrWritable = 1'b1;
      end
      if (regAddr == 8'(PAIR_ADDR_LO[k] + ADDR_PAIR_STEP)) begin
        next_rdData = pairValue[k][15:8]; // R11
        addrWritable = 1'b1;
      end
    end
    addrMapped = addrWritable;
    unique case (regAddr)
      ADDR_SENSED_TEMP_LO: begin
        next_rdData = sensedTemp[7:0]; // R14
        addrMapped = 1'b1;
      end
      ADDR_SENSED_TEMP_HI: begin
        next_rdData = sensedTemp[15:8]; // R14
        addrMapped = 1'b1;
      end
      ADDR_TEMP_FLAG: begin
        next_rdData = {4'h0, tempFlag}; // R13
        addrMapped = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData <= READ_IDLE_VALUE;
    end else if (ce && regRdEn) begin
      regRdData <= next_rdData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdValid <= 1'b0;
    end else if (ce) begin
      regRdValid <= regRdEn;
    end
  end

  // Flags a read of an unmapped address or a write to a read-only one
  always_ff @(posedge mclk) begin
    if (rst) begin
      regAccErr <= 1'b0;
    end else if (ce) begin
      regAccErr <= (regRdEn && !addrMapped) || (regWrEn && !addrWritable); // R13
    end
  end
endmodule
`default_nettype wire

// ### tb/ttl_limit_bank_props.sv
// Purpose: Port-level checks for the threshold limit bank.
// Assumes: Only top ports are visible; one clock domain.
// Notes: Attached by bind below.
`default_nettype none
module ttl_limit_bank_props
  import ttl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic regAccErr,
  input wire logic convValid,
  input wire logic overHighFlag,
  input wire logic underLowFlag,
  input wire logic overCritHighFlag,
  input wire logic underCritLowFlag,
  input wire logic cmpBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [3:0] flags;
  assign flags = {underCritLowFlag, overCritHighFlag, underLowFlag, overHighFlag};
  property p_rdAns; regRdEn && ce |=> regRdValid; endproperty
  a_rdAns: assert property (p_rdAns) else $error("read not answered");
  property p_rdCause; regRdValid |-> $past(regRdEn && ce); endproperty
  a_rdCause: assert property (p_rdCause) else $error("stray read valid");
  property p_rdHold; !(regRdEn && ce) |=> $stable(regRdData); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  property p_flagRd;
    regRdValid && $past(regAddr) == ADDR_TEMP_FLAG |-> regRdData == {4'h0, $past(flags)};
  endproperty
  a_flagRd: assert property (p_flagRd) else $error("flag register mismatch");
  property p_loZero;
    regRdValid && $past(regAddr) inside {8'h1e, 8'h20, 8'h22} |-> regRdData[1:0] == 2'b00;
  endproperty
  a_loZero: assert property (p_loZero) else $error("low byte fixed bits set");
  property p_hiZero;
    regRdValid && $past(regAddr) inside {8'h1f, 8'h21, 8'h23} |-> regRdData[7:5] == 3'b000;
  endproperty
  a_hiZero: assert property (p_hiZero) else $error("high byte fixed bits set");
  // Busy rises one edge after the taking edge, so look two edges on
  property p_busy; convValid && ce && !cmpBusy |-> ##2 cmpBusy; endproperty
  a_busy: assert property (p_busy) else $error("compare not started");
  property p_flagCause; !$stable(flags) |-> $past(cmpBusy, 2); endproperty
  a_flagCause: assert property (p_flagCause) else $error("flags moved untriggered");
  property p_roWr; regWrEn && ce && regAddr == ADDR_TEMP_FLAG |=> regAccErr; endproperty
  a_roWr: assert property (p_roWr) else $error("flag write not refused");
  c_conv: cover property (convValid && ce);
  c_flagRd: cover property (regRdValid && $past(regAddr) == ADDR_TEMP_FLAG);
  c_err: cover property (regAccErr);
endmodule
bind ttl_limit_bank ttl_limit_bank_props ttl_limit_bank_props_inst (.mclk(mclk), .rst(rst),
  .ce(ce), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regRdData(regRdData),
  .regRdValid(regRdValid), .regAccErr(regAccErr), .convValid(convValid),
  .overHighFlag(overHighFlag), .underLowFlag(underLowFlag),
  .overCritHighFlag(overCritHighFlag), .underCritLowFlag(underCritLowFlag), .cmpBusy(cmpBusy));
`default_nettype wire

// ### tb/ttl_host_model.sv
// Purpose: Host side of the register port.
// Assumes: One byte per strobe, strobes driven on the rising edge.
// Notes: Idle address and data show the inverse of the last value.
`default_nettype none
module ttl_host_model (
  input wire logic mclk,
  output var logic regWrEn,
  output var logic regRdEn,
  output var logic [7:0] regAddr,
  output var logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic regAccErr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // Valid and error stand for one cycle only, so take them in that cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic e,
    output logic v);
    @(posedge mclk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
    e = regAccErr;
    v = regRdValid;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the threshold limit bank.
// Assumes: Clock enable high except for one write in testRw; high limit supplied by the bench.
// Notes: Flags are read three edges after the taking edge.
`default_nettype none
module tb;
  import ttl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic convValid = 1'b0;
  logic [15:0] convData = 16'h0000;
  logic [15:0] highLimit = 16'h0400;
  logic regWrEn, regRdEn, regRdValid, regAccErr, cmpBusy;
  logic [7:0] regAddr, regWrData, regRdData;
  wire logic [3:0] flags;
  int badCount = 0;
  int nCompared = 0;
  always #4 mclk = ~mclk;
  ttl_host_model ttl_host_model_inst (.mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .regAccErr(regAccErr));
  ttl_limit_bank ttl_limit_bank_inst (.mclk(mclk), .rst(rst), .ce(ce), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .regAccErr(regAccErr), .convValid(convValid),
    .convData(convData), .highLimit(highLimit), .overHighFlag(flags[0]),
    .underLowFlag(flags[1]), .overCritHighFlag(flags[2]), .underCritLowFlag(flags[3]),
    .cmpBusy(cmpBusy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ttl_host_model_inst.wr(a, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input logic expErr);
    logic [7:0] d;
    logic e;
    logic v;
    ttl_host_model_inst.rd(a, d, e, v);
    chk(d, exp);
    chk({7'h00, e}, {7'h00, expErr});
    chk({7'h00, v}, 8'h01);
  endtask
  task automatic conv(input logic [15:0] t);
    @(posedge mclk);
    convValid <= 1'b1;
    convData <= t;
    @(posedge mclk);
    convValid <= 1'b0;
    convData <= ~t;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  function automatic logic [3:0] expFlags(input logic [15:0] t, input logic [15:0] lo);
    return {t < 16'h0080, t > 16'h0550, t < lo, t > highLimit};
  endfunction
  task automatic testReset;
    logic [7:0] exp [9] = '{8'h00, 8'h00, 8'h50, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rdChk(i < 6 ? 8'h1e + 8'(i) : 8'h2b + 8'(i), exp[i], 1'b0);
    end
    $display("test reset values done");
  endtask
  task automatic testRw;
    for (int i = 0; i < 6; i++) begin
      wr(8'h1e + 8'(i), 8'hff);
      rdChk(8'h1e + 8'(i), i % 2 ? 8'h1f : 8'hfc, 1'b0);
    end
    wr(8'h33, 8'hff);
    rdChk(8'h33, 8'h00, 1'b0);
    rdChk(8'h40, 8'h00, 1'b1);
    // A write offered while the clock enable is low must not land
    @(posedge mclk);
    ce <= 1'b0;
    wr(8'h1e, 8'h44);
    ce <= 1'b1;
    rdChk(8'h1e, 8'hfc, 1'b0);
    $display("test read write done");
  endtask
  task automatic testCmp;
    logic [15:0] temps [9] = '{16'h0000, 16'h007f, 16'h0080, 16'h0100, 16'h0400,
      16'h0401, 16'h0550, 16'h0551, 16'hffff};
    wr(8'h1f, 8'h01);
    wr(8'h1e, 8'h00);
    wr(8'h20, 8'h50);
    wr(8'h21, 8'h05);
    wr(8'h22, 8'h80);
    wr(8'h23, 8'h00);
    foreach (temps[i]) begin
      conv(temps[i]);
      chk({4'h0, flags}, {4'h0, expFlags(temps[i], 16'h0100)});
      rdChk(8'h31, temps[i][7:0], 1'b0);
      rdChk(8'h32, temps[i][15:8], 1'b0);
    end
    $display("test compare done");
  endtask
  task automatic testLate;
    @(posedge mclk);
    convValid <= 1'b1;
    convData <= 16'h0090;
    @(posedge mclk);
    convValid <= 1'b0;
    wr(8'h1f, 8'h00);
    @(posedge mclk);
    #1;
    chk({4'h0, flags}, 8'h02);
    conv(16'h0090);
    chk({4'h0, flags}, 8'h00);
    $display("test late write done");
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    testReset();
    testRw();
    testCmp();
    testLate();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    testReset();
    conclude();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    badCount++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire
